// *** rtl/urx_receiver.sv ***
// urx_receiver: asynchronous serial receiver with two-deep buffer and status
// assumes rx_i is synchronous to clk_i and os_tick_i pulses at the sample rate
`timescale 1ns/10ps

// What this block does
// - receive-complete flag tracks buffer non-empty
// - receiver disabled flushes buffer, clears flag
// - interrupt request is level while flag set
// - data read pops oldest frame
// - error flags travel with frame in buffer
// - status writes never alter error flags
// - error flags never raise interrupts
// - frame error reflects first stop bit
// - only first stop bit checked
// - overrun when buffer full, shifter full, start
// - overrun cleared on successful transfer
// - parity checked only when enabled; odd/even select
// - parity error valid until frame read
// - parity error zero when checking disabled
// - disable abandons reception at once
// - disable discards all unread frames
// - sample 16x normal, 8x double speed
// - falling edge starts detection, sample 1
// - vote samples 8-10 or 4-6, reject high
// - realign bit timing on each start bit
// - first stop bit moves frame to buffer
// - unused upper data bits read zero
// - three centre samples vote every bit
module urx_receiver
  import urx_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic os_tick_i,
  input wire logic rx_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rx_irq_o,
  output logic rx_pin_owned_o
);

  typedef enum logic [1:0] {URX_IDLE, URX_START, URX_BITS} urx_state_t;

  typedef struct packed {
    urx_state_t st;
    logic rx_prev;
    logic [3:0] smp;
    logic [3:0] bitn;
    logic [1:0] votes;
    logic [9:0] shf;
    logic sh_full;
    logic sh_fe;
    logic sh_pe;
    logic dor_pend;
    logic [URX_DEPTH-1:0][DW+2:0] buf_q; // {fe, dor, pe, data}
    logic rd_ptr;
    logic [1:0] count;
    logic [7:0] ctl;
    logic [7:0] fmt;
    logic ack;
    logic [31:0] dat;
  } urx_reg_t;

  urx_reg_t r_ff;
  urx_reg_t nxt_r_ff;

  logic req;
  logic rd_data;
  logic receiver_enable;
  logic u2x;
  logic [3:0] last_smp;
  logic [3:0] vote_lo;
  logic [3:0] nbits;
  logic [DW+2:0] head;
  logic [DW+2:0] pend_entry;

  // decode and mode shorthands
  assign req = wb_cyc_i && wb_stb_i && !r_ff.ack;
  assign rd_data = req && !wb_we_i && (wb_adr_i == URX_DATA_OFS) && wb_sel_i[0];
  assign receiver_enable = r_ff.ctl[URX_CT_RECEIVER_ENABLE_POS];
  assign u2x = r_ff.fmt[URX_FM_U2X_POS];
  assign last_smp = u2x ? URX_OS_DOUBLE : URX_OS_NORMAL;
  assign vote_lo = u2x ? URX_VOTE_D : URX_VOTE_N;
  // data bits + optional parity + one stop bit
  assign nbits = 4'h5 + {2'b00, r_ff.fmt[URX_FM_DSIZE_POS +: 2]}
    + {3'b000, r_ff.fmt[URX_FM_PARITY_ENABLE_BIT_POS]} + 4'h1;
  assign head = r_ff.buf_q[r_ff.rd_ptr];
  // buffer entry that the waiting frame would become, watched by the checks
  assign pend_entry = {r_ff.sh_fe, r_ff.dor_pend, r_ff.sh_pe, r_ff.shf[DW-1:0]};

  // outputs
  assign wb_ack_o = r_ff.ack;
  assign wb_dat_o = r_ff.dat;
  assign rx_irq_o = r_ff.ctl[URX_CT_RX_COMPLETE_IRQ_ENABLE_POS] && (r_ff.count != 2'b00);
  assign rx_pin_owned_o = receiver_enable;

  // next-state logic for the whole receiver
  always_comb begin
    logic smp_bit;
    logic voted;
    logic [3:0] dpos;
    logic [7:0] dmask;
    logic par;
    logic push;
    logic pop;
    logic [DW+2:0] entry;
    smp_bit = 1'b0;
    voted = 1'b0;
    dpos = 4'h0;
    dmask = 8'h00;
    par = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    entry = '0;
    nxt_r_ff = r_ff;
    nxt_r_ff.ack = req;
    // bus writes; status has no writable bits so error flags stay put
    if (req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == URX_CONTROL_OFS) begin
        nxt_r_ff.ctl = wb_dat_i[7:0];
      end
      if (wb_adr_i == URX_FORMAT_OFS) begin
        nxt_r_ff.fmt = wb_dat_i[7:0];
      end
    end
    // bus reads
    nxt_r_ff.dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        URX_STATUS_OFS: begin
          nxt_r_ff.dat[URX_ST_RXC_POS] = (r_ff.count != 2'b00);
          if (r_ff.count != 2'b00) begin
            nxt_r_ff.dat[URX_ST_FE_POS] = head[DW+2];
            nxt_r_ff.dat[URX_ST_DOR_POS] = head[DW+1];
            nxt_r_ff.dat[URX_ST_PE_POS] = head[DW];
          end
        end
        URX_CONTROL_OFS: nxt_r_ff.dat[7:0] = r_ff.ctl;
        URX_FORMAT_OFS: nxt_r_ff.dat[7:0] = r_ff.fmt;
        URX_DATA_OFS: nxt_r_ff.dat[DW-1:0] = (r_ff.count != 2'b00) ? head[DW-1:0] : '0;
        default: nxt_r_ff.dat = 32'h0000_0000;
      endcase
    end
    pop = rd_data && (r_ff.count != 2'b00);
    // sampling state machine, one step per oversample tick
    if (os_tick_i) begin
      smp_bit = rx_i;
      nxt_r_ff.rx_prev = rx_i;
      case (r_ff.st)
        URX_IDLE: begin
          if (r_ff.rx_prev && !rx_i) begin
            nxt_r_ff.st = URX_START;
            nxt_r_ff.smp = 4'h1;
            nxt_r_ff.votes = 2'b00;
            if (r_ff.sh_full && (r_ff.count == 2'(URX_DEPTH))) begin
              nxt_r_ff.sh_full = 1'b0;
              nxt_r_ff.dor_pend = 1'b1;
            end
          end
        end
        URX_START: begin
          if (r_ff.smp >= vote_lo && r_ff.smp <= vote_lo + 4'h2 && smp_bit) begin
            nxt_r_ff.votes = r_ff.votes + 2'b01;
          end
          if (r_ff.smp == vote_lo + 4'h2) begin
            if ((r_ff.votes + {1'b0, smp_bit}) >= 2'b10) begin
              nxt_r_ff.st = URX_IDLE;
            end else begin
              nxt_r_ff.st = URX_BITS;
              nxt_r_ff.bitn = 4'h0;
              nxt_r_ff.votes = 2'b00;
            end
          end
          nxt_r_ff.smp = r_ff.smp + 4'h1;
        end
        URX_BITS: begin
          // sample numbers run 1..last_smp+1, bit boundary follows the start bit
          nxt_r_ff.smp = (r_ff.smp == last_smp + 4'h1) ? 4'h1 : r_ff.smp + 4'h1;
          if (r_ff.smp >= vote_lo && r_ff.smp <= vote_lo + 4'h2 && smp_bit) begin
            nxt_r_ff.votes = r_ff.votes + 2'b01;
          end
          if (r_ff.smp == vote_lo + 4'h2) begin
            voted = (r_ff.votes + {1'b0, smp_bit}) >= 2'b10;
            nxt_r_ff.votes = 2'b00;
            nxt_r_ff.shf = {voted, r_ff.shf[9:1]};
            nxt_r_ff.bitn = r_ff.bitn + 4'h1;
            if (r_ff.bitn + 4'h1 == nbits) begin
              nxt_r_ff.st = URX_IDLE;
              nxt_r_ff.sh_full = 1'b1;
              nxt_r_ff.sh_fe = !voted;
              nxt_r_ff.shf = {voted, r_ff.shf[9:1]} >> (4'hA - nbits);
            end
          end
        end
        default: nxt_r_ff.st = URX_IDLE;
      endcase
    end
    // parity check on the aligned frame once captured
    if (nxt_r_ff.sh_full && !r_ff.sh_full) begin
      dpos = 4'h5 + {2'b00, r_ff.fmt[URX_FM_DSIZE_POS +: 2]};
      dmask = 8'hFF >> (4'h8 - dpos);
      par = ^(nxt_r_ff.shf[7:0] & dmask) ^ nxt_r_ff.shf[dpos] ^ r_ff.fmt[URX_FM_PARITY_ODD_SELECT_POS];
      nxt_r_ff.sh_pe = r_ff.fmt[URX_FM_PARITY_ENABLE_BIT_POS] && par;
      nxt_r_ff.shf = {2'b00, nxt_r_ff.shf[7:0] & dmask};
    end
    // move a waiting frame into the buffer when room exists
    push = r_ff.sh_full && ((r_ff.count < 2'(URX_DEPTH)) || pop);
    entry = {r_ff.sh_fe, r_ff.dor_pend, r_ff.sh_pe, r_ff.shf[DW-1:0]};
    if (push) begin
      nxt_r_ff.buf_q[r_ff.rd_ptr ^ r_ff.count[0]] = entry;
      nxt_r_ff.sh_full = 1'b0;
      nxt_r_ff.dor_pend = 1'b0;
    end
    if (pop) begin
      nxt_r_ff.rd_ptr = !r_ff.rd_ptr;
    end
    nxt_r_ff.count = r_ff.count + {1'b0, push} - {1'b0, pop};
    // disabling is immediate and drops everything
    if (!nxt_r_ff.ctl[URX_CT_RECEIVER_ENABLE_POS]) begin
      nxt_r_ff.st = URX_IDLE;
      nxt_r_ff.rx_prev = 1'b1;
      nxt_r_ff.count = 2'b00;
      nxt_r_ff.sh_full = 1'b0;
      nxt_r_ff.dor_pend = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_ff <= '0;
      r_ff.rx_prev <= 1'b1;
      r_ff.ctl <= URX_CONTROL_RST;
      r_ff.fmt <= URX_FORMAT_RST;
    end else begin
      r_ff <= nxt_r_ff;
    end
  end

  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_irq_o == (r_ff.ctl[URX_CT_RX_COMPLETE_IRQ_ENABLE_POS] && r_ff.count != 2'b00))
    else $error("interrupt not level of flag");
  disable_flush_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !nxt_r_ff.ctl[URX_CT_RECEIVER_ENABLE_POS] |=> r_ff.count == 2'b00 && r_ff.st == URX_IDLE)
    else $error("disable did not flush");
  pop_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_data && r_ff.count == 2'b10 && !r_ff.sh_full && receiver_enable
    |=> r_ff.count == 2'b01)
    else $error("data read did not pop");
  depth_max_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r_ff.count <= 2'(URX_DEPTH))
    else $error("buffer above depth");
  status_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && wb_adr_i == URX_STATUS_OFS && !rd_data |=> $stable(r_ff.ctl))
    else $error("status write changed state");
  parity_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(r_ff.sh_full) && !r_ff.fmt[URX_FM_PARITY_ENABLE_BIT_POS] |-> !r_ff.sh_pe)
    else $error("parity error while disabled");
  sequence start_seen_s;
    os_tick_i && r_ff.st == URX_IDLE && r_ff.rx_prev && !rx_i && receiver_enable;
  endsequence
  start_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_seen_s |=> r_ff.smp == 4'h1 && (r_ff.st == URX_START || !receiver_enable))
    else $error("start not numbered sample one");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // checks below guard buffer moves, overrun and the bus answer
  sequence frame_waiting_s;
    r_ff.sh_full && receiver_enable && !req;
  endsequence
  sequence buffer_full_s;
    r_ff.count == 2'(URX_DEPTH);
  endsequence

  // an idle start with a full buffer and a waiting frame marks overrun
  overrun_mark_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_seen_s and frame_waiting_s and buffer_full_s |=> r_ff.dor_pend && !r_ff.sh_full)
    else $error("overrun not marked");

  // a waiting frame enters an empty buffer with its own flags
  push_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_waiting_s ##0 r_ff.count == 2'b00 |=> r_ff.count == 2'b01 && head == $past(pend_entry))
    else $error("frame not moved to buffer");

  // a successful move clears the pending overrun mark
  overrun_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_waiting_s ##0 r_ff.count != 2'(URX_DEPTH) |=> !r_ff.dor_pend)
    else $error("overrun mark not cleared");

  // status of an empty buffer shows no flag at all
  status_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !wb_we_i && wb_adr_i == URX_STATUS_OFS && r_ff.count == 2'b00 |=> wb_dat_o == 32'h0000_0000)
    else $error("flags shown while empty");

  // an empty data read answers zero and leaves the buffer empty
  data_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_data && r_ff.count == 2'b00 && !r_ff.sh_full |=> wb_dat_o == 32'h0000_0000 && r_ff.count == 2'b00)
    else $error("empty read popped or returned data");

  // read data never carries bits above the register byte
  upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  // error flags alone never raise the request line
  irq_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    r_ff.count == 2'b00 |-> !rx_irq_o)
    else $error("interrupt with empty buffer");

  // with the receiver off the sampler stays idle and the buffer empty
  off_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !receiver_enable |-> r_ff.st == URX_IDLE && r_ff.count == 2'b00)
    else $error("receiver active while disabled");

  // every taken request is answered on the next edge
  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not answered");

  // the third start vote always ends the start state
  start_decide_a: assert property (@(posedge clk_i) disable iff (rst_i)
    os_tick_i && r_ff.st == URX_START && r_ff.smp == vote_lo + 4'h2 |=> r_ff.st != URX_START)
    else $error("start bit not decided");

  // an accepted start bit restarts the bit count
  bits_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    os_tick_i && r_ff.st == URX_START && r_ff.smp == vote_lo + 4'h2 |=> r_ff.st == URX_IDLE || r_ff.bitn == 4'h0)
    else $error("bit timing not realigned");

endmodule : urx_receiver

// *** inc/urx_pkg.sv ***
// urx_pkg: register map, field positions and reset values of the serial receiver
// assumes a classic wishbone slave with 32-bit data and word-aligned registers
package urx_pkg;
  // register byte offsets
  localparam logic [3:0] URX_STATUS_OFS = 4'h0; // serial_status_reg
  localparam logic [3:0] URX_CONTROL_OFS = 4'h4; // serial_control_reg
  localparam logic [3:0] URX_FORMAT_OFS = 4'h8; // serial_format_reg
  localparam logic [3:0] URX_DATA_OFS = 4'hC; // serial_data_reg
  // status fields
  localparam int URX_ST_PE_POS = 2;
  localparam int URX_ST_DOR_POS = 3;
  localparam int URX_ST_FE_POS = 4;
  localparam int URX_ST_RXC_POS = 7;
  // control fields
  localparam int URX_CT_RECEIVER_ENABLE_POS = 4;
  localparam int URX_CT_RX_COMPLETE_IRQ_ENABLE_POS = 7;
  // format fields
  localparam int URX_FM_DSIZE_POS = 0; // 2-bit: 5..8 data bits
  localparam int URX_FM_STOP_BIT_COUNT_SELECT_POS = 3;
  localparam int URX_FM_PARITY_ODD_SELECT_POS = 4;
  localparam int URX_FM_PARITY_ENABLE_BIT_POS = 5;
  localparam int URX_FM_U2X_POS = 6;
  // reset values
  localparam logic [7:0] URX_CONTROL_RST = 8'h00;
  localparam logic [7:0] URX_FORMAT_RST = 8'h03;
  // sampling
  localparam logic [3:0] URX_OS_NORMAL = 4'hF; // last sample index, 16 per bit
  localparam logic [3:0] URX_OS_DOUBLE = 4'h7; // last sample index, 8 per bit
  localparam logic [3:0] URX_VOTE_N = 4'h8; // first voted sample, normal
  localparam logic [3:0] URX_VOTE_D = 4'h4; // first voted sample, double speed
  localparam int URX_DEPTH = 2;
endpackage : urx_pkg

// *** sim/urx_tx_model.sv ***
// urx_tx_model: remote asynchronous serial transmitter driving the receive line
// assumes one oversample tick per clock, so a bit lasts spb clock cycles
`timescale 1ns/10ps
module urx_tx_model (
  input wire logic clk_i,
  output logic rx_o
);
  // line idles high between frames
  initial rx_o = 1'b1;

  // hold one line level for a whole bit period
  task automatic bit_out(input logic b, input int spb);
    @(posedge clk_i);
    rx_o <= b;
    repeat (spb - 1) @(posedge clk_i);
  endtask : bit_out

  // start bit, data lsb first, optional parity, one stop, one idle bit
  task automatic send(input logic [7:0] d, input int n, input logic pon, input logic pb,
                      input logic stop, input int spb);
    bit_out(1'b0, spb);
    for (int i = 0; i < n; i++) begin
      bit_out(d[i], spb);
    end
    if (pon) begin
      bit_out(pb, spb);
    end
    bit_out(stop, spb);
    bit_out(1'b1, spb);
  endtask : send

  // low pulse of eight samples: samples 8, 9 and 10 see the line high again
  task automatic spike();
    bit_out(1'b0, 8);
    bit_out(1'b1, 1);
  endtask : spike
endmodule : urx_tx_model

// *** sim/test_urx_receiver.sv ***
// test_urx_receiver: register level tests of the serial receiver
// assumes the transmitter model on rx_i, one oversample tick per 100 ns clock
`timescale 1ns/10ps
module test_urx_receiver;
  import urx_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rx_irq_o, rx_pin_owned_o, rx;
  int fail_count = 0;
  int tests_run = 0;

  // clock of 100 ns period
  initial forever #50 clk_i = ~clk_i;

  urx_tx_model i_urx_tx_model (.clk_i(clk_i), .rx_o(rx));
  urx_receiver i_urx_receiver (.clk_i(clk_i), .rst_i(rst_i), .os_tick_i(1'b1), .rx_i(rx), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .rx_irq_o(rx_irq_o), .rx_pin_owned_o(rx_pin_owned_o));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask : wb

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic send(input logic [7:0] d, input int spb);
    i_urx_tx_model.send(d, 8, 1'b0, 1'b0, 1'b1, spb);
  endtask : send

  // print counts and verdict, end the run
  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // watchdog well beyond the few thousand cycles of the tests
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(URX_CONTROL_OFS, URX_CONTROL_RST);
    rd(URX_FORMAT_OFS, URX_FORMAT_RST);
    rd(URX_STATUS_OFS, 8'h00);
    rd(4'h2, 8'h00);
    wr(URX_CONTROL_OFS, 8'h10);
    chk({31'h0, rx_pin_owned_o}, 32'h1);
    send(8'h5A, 16);
    chk({31'h0, rx_irq_o}, 32'h0);
    rd(URX_STATUS_OFS, 8'h80);
    wr(URX_CONTROL_OFS, 8'h90);
    chk({31'h0, rx_irq_o}, 32'h1);
    rd(URX_DATA_OFS, 8'h5A);
    rd(URX_STATUS_OFS, 8'h00);
    // bad stop bit with two stop bits selected
    wr(URX_FORMAT_OFS, 8'h0B);
    i_urx_tx_model.send(8'hC3, 8, 1'b0, 1'b0, 1'b0, 16);
    wr(URX_STATUS_OFS, 8'h00);
    rd(URX_STATUS_OFS, 8'h90);
    rd(URX_DATA_OFS, 8'hC3);
    // set parity bit on a frame with four ones, even then odd checking
    for (int i = 0; i < 2; i++) begin
      wr(URX_FORMAT_OFS, (i != 0) ? 8'h33 : 8'h23);
      i_urx_tx_model.send(8'h35, 8, 1'b1, 1'b1, 1'b1, 16);
      rd(URX_STATUS_OFS, (1'b1 != ((i != 0) ? ~^8'h35 : ^8'h35)) ? 8'h84 : 8'h80);
      rd(URX_DATA_OFS, 8'h35);
      rd(URX_STATUS_OFS, 8'h00);
    end
    // five data bits, upper bits read zero
    wr(URX_FORMAT_OFS, 8'h00);
    i_urx_tx_model.send(8'hFF, 5, 1'b0, 1'b0, 1'b1, 16);
    rd(URX_DATA_OFS, 8'h1F);
    // double speed, eight samples a bit
    wr(URX_FORMAT_OFS, 8'h43);
    send(8'hA5, 8);
    rd(URX_DATA_OFS, 8'hA5);
    // short low pulse is no start bit
    wr(URX_FORMAT_OFS, 8'h03);
    i_urx_tx_model.spike();
    repeat (40) @(posedge clk_i);
    rd(URX_STATUS_OFS, 8'h00);
    // third frame lost when the fourth starts
    send(8'h11, 16);
    send(8'h22, 16);
    send(8'h33, 16);
    fork
      send(8'h44, 16);
    join_none
    repeat (40) @(posedge clk_i);
    rd(URX_STATUS_OFS, 8'h80);
    rd(URX_DATA_OFS, 8'h11);
    rd(URX_DATA_OFS, 8'h22);
    wait fork;
    rd(URX_STATUS_OFS, 8'h88);
    rd(URX_DATA_OFS, 8'h44);
    send(8'h55, 16);
    rd(URX_STATUS_OFS, 8'h80);
    rd(URX_DATA_OFS, 8'h55);
    // disable with a frame buffered
    send(8'h66, 16);
    wr(URX_CONTROL_OFS, 8'h80);
    chk({31'h0, rx_irq_o}, 32'h0);
    chk({31'h0, rx_pin_owned_o}, 32'h0);
    rd(URX_STATUS_OFS, 8'h00);
    // disable in mid frame drops the frame
    wr(URX_CONTROL_OFS, 8'h90);
    fork
      send(8'h77, 16);
    join_none
    repeat (60) @(posedge clk_i);
    wr(URX_CONTROL_OFS, 8'h80);
    wait fork;
    wr(URX_CONTROL_OFS, 8'h90);
    repeat (20) @(posedge clk_i);
    rd(URX_STATUS_OFS, 8'h00);
    stop_test();
  end
endmodule : test_urx_receiver
